// *** design/scs_defs.vh ***
// Constants of the conversion sequencer: offsets, fields, reset values, timing
// Summary of operation
// - Conversion equals sampling plus approximation time
// - Stop aborts conversion, result register unchanged
// - Stop also resets sequence position to start
// - Stop end clears stop and start bits
// - Edge field: off, rising, falling, both
// - Triggers ignored while start bit clear
// - Triggers during conversion ignored, never queued
// - Source field: timer1 trigger or channel4
// - Start bit acts as software trigger
// - Resolution 12/10/8/6 sets approximation length
// - Conversion-done flag set on new result
// - Conversion-done clears on write-one or read
// - Sampling-done flag per sample, write-one clears
// - Sequence-done flag on last result, write-one
// - Sixteen-bit result, right or left justified
// - Overrun when result lands with done set
// - Keep converting after overrun; write-one clears
// - Overwrite select 0 keeps old result
// - Overwrite select 1 stores every result
// - No edge selected: start converts immediately
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH
// Register byte offsets
`define SCS_OFF_STATUS 8'h00
`define SCS_OFF_IRQEN  8'h04
`define SCS_OFF_CTRL   8'h08
`define SCS_OFF_CFG    8'h0C
`define SCS_OFF_DATA   8'h10
// Status and interrupt enable bit positions
`define SCS_B_SMP  1
`define SCS_B_EOC  2
`define SCS_B_SEQ  3
`define SCS_B_OVR  4
`define SCS_IRQEN_MASK 32'h0000001E
// Control bit positions
`define SCS_B_START 2
`define SCS_B_STOP  4
// Configuration fields
`define SCS_F_RES_LO  3
`define SCS_B_ALIGN   5
`define SCS_F_SRC_LO  6
`define SCS_F_EDGE_LO 10
`define SCS_B_OVRSEL  12
`define SCS_B_CONT    13
`define SCS_F_LEN_LO  16
`define SCS_CFG_MASK  32'h000F3FF8
`define SCS_CFG_RESET 32'h00000000
// Converter clock runs at half the system clock: one half cycle per tick
`define SCS_HALF_PER_CYC 2
`define SCS_SMP_TENTHS   35
`endif

// *** design/scs_sequencer.v ***
// Conversion sequencer of a successive-approximation converter with AXI4-Lite registers
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_sequencer #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input  wire              CLK_SYS,
  input  wire              RESETN,
  // AXI4-Lite write
  input  wire [ADDR_W-1:0] AWADDR,
  input  wire              AWVALID,
  output wire              AWREADY,
  input  wire [31:0]       WDATA,
  input  wire [3:0]        WSTRB,
  input  wire              WVALID,
  output wire              WREADY,
  output wire [1:0]        BRESP,
  output wire              BVALID,
  input  wire              BREADY,
  // AXI4-Lite read
  input  wire [ADDR_W-1:0] ARADDR,
  input  wire              ARVALID,
  output wire              ARREADY,
  output wire [31:0]       RDATA,
  output wire [1:0]        RRESP,
  output wire              RVALID,
  input  wire              RREADY,
  // Timer trigger pins
  input  wire              TRIG_TIMER1_OUT,
  input  wire              TRIG_TIMER1_CC4,
  // Analog core and interrupt
  input  wire [11:0]       ANA_CODE,
  output wire [1:0]        ANA_PHASE,
  output wire [3:0]        ANA_CHANNEL,
  output wire              IRQ
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_SAMP = 2'h2;
  localparam ST_CONV = 2'h3;
  // Sampling length in system cycles, cut to the counter width on purpose
  localparam integer SMP_CYC_I = `SCS_SMP_TENTHS * `SCS_HALF_PER_CYC / 10;
  localparam [5:0]   SMP_CYC   = SMP_CYC_I[5:0];

  // Bus handshake state
  reg              awready;
  reg              wready;
  reg              bvalid;
  reg [1:0]        bresp;
  reg              arready;
  reg              rvalid;
  reg [31:0]       rdata;
  reg [1:0]        rresp;
  reg [ADDR_W-1:0] aw_addr;
  reg              aw_held;
  reg [31:0]       w_data;
  reg [3:0]        w_strb;
  reg              w_held;
  // Block state
  reg [1:0]        state;
  reg [5:0]        cnt;
  reg [3:0]        pos;
  reg              start;
  reg              stop;
  reg [31:0]       cfg;
  reg [31:0]       irq_en;
  reg              f_smp;
  reg              f_eoc;
  reg              f_seq;
  reg              f_ovr;
  reg [15:0]       result;
  reg              irq;
  // Trigger synchroniser
  wire [1:0]       lvl;
  reg              prev;

  wire [1:0]  res     = cfg[`SCS_F_RES_LO+1:`SCS_F_RES_LO];
  wire        align   = cfg[`SCS_B_ALIGN];
  wire [2:0]  src     = cfg[`SCS_F_SRC_LO+2:`SCS_F_SRC_LO];
  wire [1:0]  edge_s  = cfg[`SCS_F_EDGE_LO+1:`SCS_F_EDGE_LO];
  wire        ovr_sel = cfg[`SCS_B_OVRSEL];
  wire        cont    = cfg[`SCS_B_CONT];
  wire [3:0]  seq_len = cfg[`SCS_F_LEN_LO+3:`SCS_F_LEN_LO];

  // Resolution in bits and approximation length in half cycles
  wire [3:0]  bits    = 4'hC - {1'b0, res, 1'b0};
  wire [5:0]  sar_cyc = {1'b0, bits, 1'b1};

  wire do_wr = aw_held & w_held & ~bvalid;
  wire rd_hit = ARVALID & arready;
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] wbits = w_data & wmask;

  reg  [4:0]  wsel;
  always @* begin
    wsel = 5'h00;
    if (aw_addr == `SCS_OFF_STATUS) begin
      wsel[0] = 1'b1;
    end else if (aw_addr == `SCS_OFF_IRQEN) begin
      wsel[1] = 1'b1;
    end else if (aw_addr == `SCS_OFF_CTRL) begin
      wsel[2] = 1'b1;
    end else if (aw_addr == `SCS_OFF_CFG) begin
      wsel[3] = 1'b1;
    end else if (aw_addr == `SCS_OFF_DATA) begin
      wsel[4] = 1'b1;
    end
  end

  wire [31:0] status = {27'h0, f_ovr, f_seq, f_eoc, f_smp, 1'b0};
  reg  [31:0] rd_mux;
  reg         rd_err;
  reg         rd_data;
  always @* begin
    rd_mux = 32'h0;
    rd_err = 1'b0;
    rd_data = 1'b0;
    if (ARADDR == `SCS_OFF_STATUS) begin
      rd_mux = status;
    end else if (ARADDR == `SCS_OFF_IRQEN) begin
      rd_mux = irq_en;
    end else if (ARADDR == `SCS_OFF_CTRL) begin
      rd_mux = {27'h0, stop, 1'b0, start, 2'h0};
    end else if (ARADDR == `SCS_OFF_CFG) begin
      rd_mux = cfg;
    end else if (ARADDR == `SCS_OFF_DATA) begin
      rd_mux = {16'h0, result};
      rd_data = 1'b1;
    end else begin
      rd_err = 1'b1;
    end
  end

  // Trigger selection and edge detection
  wire sel_lvl = (src == 3'h0) ? lvl[0] : ((src == 3'h1) ? lvl[1] : 1'b0);
  wire rise = sel_lvl & ~prev;
  wire fall = ~sel_lvl & prev;
  reg  hit;
  always @* begin
    case (edge_s)
      2'h1:    hit = rise;
      2'h2:    hit = fall;
      2'h3:    hit = rise | fall;
      default: hit = 1'b0;
    endcase
  end

  // Result shaping: keep the top bits of the code for the chosen resolution
  wire [11:0] keep   = 12'hFFF << (4'hC - bits);
  wire [11:0] code_m = ANA_CODE & keep;
  wire [15:0] right  = {4'h0, code_m} >> (4'hC - bits);
  wire [15:0] left   = {code_m, 4'h0};
  wire [15:0] shaped = align ? left : right;

  wire last     = (pos == seq_len);
  // Preserve mode drops results while an unread one or an overrun is pending
  wire drop     = ~ovr_sel & (f_eoc | f_ovr);

  wire [1:0] trig_pin = {TRIG_TIMER1_CC4, TRIG_TIMER1_OUT};

  // Three stages per pin; the filtered level follows only when stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      reg s1;
      reg s2;
      reg s3;
      reg flt;
      always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          flt <= 1'b0;
        end else begin
          s1 <= trig_pin[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            flt <= s3;
          end
        end
      end
      assign lvl[gi] = flt;
    end
  endgenerate

  // Previous level of the selected source, tracked in every state so no edge is queued
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      prev <= 1'b0;
    end else begin
      prev <= sel_lvl;
    end
  end

  // Bus channels
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
      aw_addr <= {ADDR_W{1'b0}};
      aw_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      w_held <= 1'b0;
    end else begin
      if (AWVALID && awready) begin
        aw_addr <= AWADDR;
        aw_held <= 1'b1;
        awready <= 1'b0;
      end
      if (WVALID && wready) begin
        w_data <= WDATA;
        w_strb <= WSTRB;
        w_held <= 1'b1;
        wready <= 1'b0;
      end
      if (do_wr) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (wsel == 5'h00) ? 2'h2 : 2'h0;
      end
      if (bvalid && BREADY) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      if (rd_hit) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_err ? 2'h2 : 2'h0;
      end
      if (rvalid && RREADY) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Sequencer, flags and registers
  always @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state <= ST_IDLE;
      cnt <= 6'h00;
      pos <= 4'h0;
      start <= 1'b0;
      stop <= 1'b0;
      cfg <= `SCS_CFG_RESET;
      irq_en <= 32'h0;
      f_smp <= 1'b0;
      f_eoc <= 1'b0;
      f_seq <= 1'b0;
      f_ovr <= 1'b0;
      result <= 16'h0;
      irq <= 1'b0;
    end else begin
      irq <= |(status & irq_en);
      // Clears first so that a same-cycle set wins
      if (do_wr && wsel[0]) begin
        if (wbits[`SCS_B_SMP]) f_smp <= 1'b0;
        if (wbits[`SCS_B_EOC]) f_eoc <= 1'b0;
        if (wbits[`SCS_B_SEQ]) f_seq <= 1'b0;
        if (wbits[`SCS_B_OVR]) f_ovr <= 1'b0;
      end
      if (rd_hit && rd_data) begin
        f_eoc <= 1'b0;
      end
      if (do_wr && wsel[1]) begin
        irq_en <= ((irq_en & ~wmask) | wbits) & `SCS_IRQEN_MASK;
      end
      if (do_wr && wsel[3]) begin
        cfg <= ((cfg & ~wmask) | wbits) & `SCS_CFG_MASK;
      end
      case (state)
        ST_WAIT: begin
          if (hit) begin
            state <= ST_SAMP;
            cnt <= SMP_CYC - 6'h01;
          end
        end
        ST_SAMP: begin
          if (cnt == 6'h00) begin
            // A sample ending in the stop cycle raises no flag
            if (!stop) begin
              f_smp <= 1'b1;
            end
            state <= ST_CONV;
            cnt <= sar_cyc - 6'h01;
          end else begin
            cnt <= cnt - 6'h01;
          end
        end
        ST_CONV: begin
          if (cnt != 6'h00) begin
            cnt <= cnt - 6'h01;
          end else if (!stop) begin
            if (!drop) begin
              result <= shaped;
            end
            f_eoc <= 1'b1;
            if (f_eoc) begin
              f_ovr <= 1'b1;
            end
            if (last) begin
              f_seq <= 1'b1;
              pos <= 4'h0;
            end else begin
              pos <= pos + 4'h1;
            end
            // Converting goes on after an overrun
            if (!last || cont) begin
              state <= ST_SAMP;
              cnt <= SMP_CYC - 6'h01;
            end else if (edge_s != 2'h0) begin
              state <= ST_WAIT;
            end else begin
              state <= ST_IDLE;
              start <= 1'b0;
            end
          end
        end
        default: begin
        end
      endcase
      if (stop) begin
        state <= ST_IDLE;
        pos <= 4'h0;
        start <= 1'b0;
        stop <= 1'b0;
      end else if (do_wr && wsel[2]) begin
        if (wbits[`SCS_B_STOP] && start) begin
          stop <= 1'b1;
        end else if (wbits[`SCS_B_START] && !start && state == ST_IDLE) begin
          start <= 1'b1;
          if (edge_s == 2'h0) begin
            state <= ST_SAMP;
            cnt <= SMP_CYC - 6'h01;
          end else begin
            state <= ST_WAIT;
          end
        end
      end
    end
  end

  assign AWREADY = awready;
  assign WREADY = wready;
  assign BVALID = bvalid;
  assign BRESP = bresp;
  assign ARREADY = arready;
  assign RVALID = rvalid;
  assign RDATA = rdata;
  assign RRESP = rresp;
  assign ANA_PHASE = state;
  assign ANA_CHANNEL = pos;
  assign IRQ = irq;
endmodule

// *** test/scs_chk_sva.sv ***
// Port assertions of the conversion sequencer
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_chk #(
  parameter ADDR_W = 8
) (
  // Clock and reset
  input wire logic              CLK_SYS,
  input wire logic              RESETN,
  // Register bus
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic              AWVALID,
  input wire logic              AWREADY,
  input wire logic [31:0]       WDATA,
  input wire logic              WVALID,
  input wire logic              WREADY,
  input wire logic [1:0]        BRESP,
  input wire logic              BVALID,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic              ARVALID,
  input wire logic              ARREADY,
  input wire logic [31:0]       RDATA,
  input wire logic [1:0]        RRESP,
  input wire logic              RVALID,
  // Analog core
  input wire logic [1:0]        ANA_PHASE,
  input wire logic [3:0]        ANA_CHANNEL
);
  wire wr_hs  = AWVALID && AWREADY && WVALID && WREADY;
  wire wr_ctl = wr_hs && AWADDR == `SCS_OFF_CTRL;
  wire rd_hs  = ARVALID && ARREADY;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);
  chk_sample_len: assert property ($rose(ANA_PHASE == 2'h2) |-> (ANA_PHASE == 2'h2)[*7] ##1 ANA_PHASE == 2'h3)
    else $error("sampling phase length wrong");
  chk_approx_len: assert property ($rose(ANA_PHASE == 2'h3) |-> (ANA_PHASE == 2'h3)[*8] ##[6:18] ANA_PHASE != 2'h3)
    else $error("approximation phase length wrong");
  chk_idle_hold: assert property (ANA_PHASE == 2'h0 && !AWVALID && !$past(AWVALID) |=> ANA_PHASE == 2'h0)
    else $error("left idle without a start write");
  chk_stop_idle: assert property (wr_ctl && WDATA[`SCS_B_STOP] |-> ##[1:4] ANA_PHASE == 2'h0)
    else $error("stop did not reach idle");
  chk_stop_chan: assert property (wr_ctl && WDATA[`SCS_B_STOP] |-> ##[1:4] ANA_CHANNEL == 4'h0)
    else $error("stop did not rewind the sequence");
  chk_start_go: assert property (wr_ctl && WDATA[`SCS_B_START] && ANA_PHASE == 2'h0 |-> ##[1:4] ANA_PHASE != 2'h0)
    else $error("start write did not leave idle");
  chk_data_top: assert property (rd_hs && ARADDR == `SCS_OFF_DATA |=> RVALID && RDATA[31:16] == 16'h0000)
    else $error("result upper half not zero");
  chk_write_resp: assert property (wr_hs && AWADDR[1:0] == 2'h0 && AWADDR <= `SCS_OFF_DATA |-> ##[1:2] BVALID && BRESP == 2'h0)
    else $error("write response missing");
  chk_unmapped_rd: assert property (rd_hs && ARADDR == 8'h14 |=> RVALID && RRESP == 2'h2)
    else $error("unmapped read not refused");
endmodule
bind scs_sequencer scs_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// *** test/scs_timer_model.sv ***
// Timer trigger lines and analog code source facing the sequencer
`timescale 1ns/1ps
module scs_timer_model (
  // Bench control
  input wire logic        clk,
  input wire logic [1:0]  flip,
  input wire logic [11:0] code,
  // Pins toward the sequencer
  output logic            trig_out,
  output logic            trig_cc4,
  output logic [11:0]     ana_code
);
  initial begin
    trig_out = 1'b0;
    trig_cc4 = 1'b0;
  end
  // Each request toggles one timer line, giving one edge
  always @(posedge clk) begin
    if (flip[0]) trig_out <= ~trig_out;
    if (flip[1]) trig_cc4 <= ~trig_cc4;
  end
  assign ana_code = code;
endmodule

// *** test/testbench.sv ***
// Register-level bench for the conversion sequencer
`timescale 1ns/1ps
`include "scs_defs.vh"
module testbench;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, d, x;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [1:0]  flip = 2'h0, r;
  logic [11:0] code = 12'h000;
  wire         awready, wready, bvalid, arready, rvalid, irq, trig_out, trig_cc4;
  wire [1:0]   bresp, rresp, ana_phase;
  wire [31:0]  rdata;
  wire [3:0]   ana_channel;
  wire [11:0]  ana_code;
  int          n_errors = 0, checks_done = 0, cyc = 0;
  scs_sequencer dut (.CLK_SYS(clk_sys), .RESETN(resetn), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
    .RREADY(rready), .TRIG_TIMER1_OUT(trig_out), .TRIG_TIMER1_CC4(trig_cc4), .ANA_CODE(ana_code),
    .ANA_PHASE(ana_phase), .ANA_CHANNEL(ana_channel), .IRQ(irq));
  scs_timer_model far (.clk(clk_sys), .flip(flip), .code(code), .trig_out(trig_out), .trig_cc4(trig_cc4),
    .ana_code(ana_code));
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string s);
    rd(a);
    chk(s, d, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic to_ph(input logic [1:0] p);
    while (ana_phase !== p) @(posedge clk_sys);
  endtask
  task automatic tog(input logic [1:0] f);
    @(posedge clk_sys);
    flip <= f;
    @(posedge clk_sys);
    flip <= 2'h0;
  endtask
  task complete_run;
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run;
    end
  end
  initial begin
    int a, k, e, s;
    tick(4);
    resetn <= 1'b1;
    rc(`SCS_OFF_CFG, `SCS_CFG_RESET, "cfg reset");
    rc(`SCS_OFF_DATA, 32'h0, "data reset");
    rd(8'h14);
    chk("unmapped resp", {30'h0, r}, 32'h2);
    // Every resolution in both justifications
    for (a = 0; a < 8; a++) begin
      k = a >> 1;
      code <= 12'(12'hA5B + a);
      wr(`SCS_OFF_CFG, 32'((k << 3) | ((a & 1) << 5)));
      wr(`SCS_OFF_CTRL, 32'h4);
      to_ph(2'h0);
      rc(`SCS_OFF_STATUS, 32'hE, "flags");
      x = (a & 1) ? ({code, 4'h0} & (32'hFFFF << (4 + 2 * k))) : 32'(code >> (2 * k));
      rc(`SCS_OFF_DATA, x, "result");
      rc(`SCS_OFF_STATUS, 32'hA, "flags after read");
      wr(`SCS_OFF_STATUS, 32'h1E);
      rc(`SCS_OFF_STATUS, 32'h0, "flags cleared");
    end
    // Unread result, then a second conversion
    for (a = 0; a < 2; a++) begin
      wr(`SCS_OFF_CFG, 32'(a << 12));
      code <= 12'h111;
      wr(`SCS_OFF_CTRL, 32'h4);
      to_ph(2'h0);
      code <= 12'h222;
      wr(`SCS_OFF_CTRL, 32'h4);
      to_ph(2'h0);
      rc(`SCS_OFF_STATUS, 32'h1E, "overrun flags");
      wr(`SCS_OFF_IRQEN, 32'h10);
      tick(2);
      chk("overrun irq", irq, 32'h1);
      rc(`SCS_OFF_DATA, a ? 32'h222 : 32'h111, "overrun result");
      wr(`SCS_OFF_STATUS, 32'h1E);
      rc(`SCS_OFF_STATUS, 32'h0, "overrun cleared");
      chk("irq cleared", irq, 32'h0);
    end
    // Rising, falling and both edge modes on each source, rising then falling
    code <= 12'h3C3;
    for (e = 1; e < 4; e++) for (s = 0; s < 2; s++) begin
      wr(`SCS_OFF_CFG, 32'((s << 6) | (e << 10)));
      wr(`SCS_OFF_CTRL, 32'h4);
      for (k = 0; k < 2; k++) begin
        tog(2'(1 << (1 - s)));
        tick(12);
        chk("other source", ana_phase, 32'h1);
        tog(2'(1 << s));
        tick(12);
        chk("edge", ana_phase[1], k ? e >> 1 : e & 1);
        to_ph(2'h1);
      end
      wr(`SCS_OFF_CTRL, 32'h10);
      rc(`SCS_OFF_CTRL, 32'h0, "stopped");
    end
    // Edge during conversion, then edge while stopped
    wr(`SCS_OFF_CFG, 32'h3 << 10);
    wr(`SCS_OFF_CTRL, 32'h4);
    tog(2'h1);
    to_ph(2'h3);
    tog(2'h1);
    to_ph(2'h1);
    tick(12);
    chk("no queued trigger", ana_phase, 32'h1);
    wr(`SCS_OFF_CTRL, 32'h10);
    tog(2'h1);
    tick(12);
    chk("idle ignores trigger", ana_phase, 32'h0);
    // Stop in mid-conversion of the second channel of a continuous sequence
    wr(`SCS_OFF_CFG, 32'h00012000);
    wr(`SCS_OFF_STATUS, 32'h1E);
    code <= 12'hFFF;
    wr(`SCS_OFF_CTRL, 32'h4);
    while (ana_channel !== 4'h1) @(posedge clk_sys);
    rc(`SCS_OFF_DATA, 32'hFFF, "first result");
    code <= 12'h5A5;
    to_ph(2'h3);
    tick(8);
    wr(`SCS_OFF_CTRL, 32'h10);
    tick(2);
    chk("stop channel", ana_channel, 32'h0);
    chk("stop phase", ana_phase, 32'h0);
    rc(`SCS_OFF_CTRL, 32'h0, "stop clears bits");
    tick(30);
    rc(`SCS_OFF_DATA, 32'hFFF, "data kept");
    complete_run;
  end
endmodule
